// [hw/issp_regs.sv]
`timescale 1ns/1ns
`default_nettype none
module issp_regs (
    input wire logic mclk,
    input wire logic rstn,
    input wire issp_pkg::issp_req_t isa_req,
    output logic [7:0] isa_rdata,
    input wire issp_pkg::issp_req_t vme_req,
    output logic [7:0] vme_rdata,
    input wire issp_pkg::issp_pins_t pins,
    output logic fault_led
);
    import issp_pkg::*;

    issp_state_t state_reg;
    issp_state_t state_next;

    // Semaphore update with lock-bit protection
    function automatic logic [7:0] sem_write(input logic [7:0] cur, input logic [7:0] val);
        if (cur[SEM_LOCK_BIT] && val[SEM_LOCK_BIT]) begin
            return cur;
        end
        return val;
    endfunction : sem_write

    // Read decode shared by both bus sides
    function automatic logic [7:0] read_mux(input issp_state_t s, input logic [15:0] a, input issp_pins_t p);
        logic [7:0] d;
        d = UNMAPPED_READ;
        if (a == ADDR_SEM_ONE) begin
            d = s.sem_one;
        end else if (a == ADDR_SEM_TWO) begin
            d = s.sem_two;
        end else if (a == ADDR_SLOT) begin
            d = {2'b00, p.slot_parity_n, p.slot_n};
        end else if (a == ADDR_PORT_C) begin
            d = 8'h00;
            d[PORTC_TYPE_LO +: 2] = p.base_type;
        end else if (a == ADDR_PORT_B) begin
            d = 8'h00;
            d[PORTB_ABORT_BIT] = p.abort_n;
        end else if (a == ADDR_PORT_A) begin
            d = 8'h00;
            d[PORTA_FAULT_BIT] = s.port_a[PORTA_FAULT_BIT];
        end else if (a == ADDR_CONTROL) begin
            d = s.control;
        end
        return d;
    endfunction : read_mux

    // Next state; ISA write applied first, then VME, so VME wins a same-cycle tie unless both set the lock bit,
    // when a free semaphore takes ISA's write and a held one keeps its value
    always_comb begin
        state_next = state_reg;
        if (isa_req.rd) begin
            state_next.isa_rdata = read_mux(state_reg, isa_req.addr, pins);
        end
        if (vme_req.rd) begin
            state_next.vme_rdata = read_mux(state_reg, vme_req.addr, pins);
        end
        if (isa_req.wr) begin
            if (isa_req.addr == ADDR_SEM_ONE) begin
                state_next.sem_one = sem_write(state_next.sem_one, isa_req.wdata);
            end else if (isa_req.addr == ADDR_SEM_TWO) begin
                state_next.sem_two = sem_write(state_next.sem_two, isa_req.wdata);
            end else if (isa_req.addr == ADDR_PORT_A) begin
                state_next.port_a = isa_req.wdata;
            end else if (isa_req.addr == ADDR_CONTROL) begin
                state_next.control = isa_req.wdata;
            end
        end
        if (vme_req.wr) begin
            if (vme_req.addr == ADDR_SEM_ONE) begin
                state_next.sem_one = sem_write(state_next.sem_one, vme_req.wdata);
            end else if (vme_req.addr == ADDR_SEM_TWO) begin
                state_next.sem_two = sem_write(state_next.sem_two, vme_req.wdata);
            end
        end
    end

    // State register; other addresses (DMA, acknowledge) hit nothing
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_reg <= '{SEM_RESET, SEM_RESET, PORT_A_RESET, CONTROL_RESET, 8'h00, 8'h00};
        end else begin
            state_reg <= state_next;
        end
    end

    assign isa_rdata = state_reg.isa_rdata;
    assign vme_rdata = state_reg.vme_rdata;
    assign fault_led = state_reg.port_a[PORTA_FAULT_BIT];

    // Local address hits a mapped register; anything else must read as unmapped
    logic isa_hit;
    assign isa_hit = isa_req.addr == ADDR_SEM_ONE || isa_req.addr == ADDR_SEM_TWO || isa_req.addr == ADDR_SLOT
        || isa_req.addr == ADDR_PORT_C || isa_req.addr == ADDR_PORT_B || isa_req.addr == ADDR_PORT_A
        || isa_req.addr == ADDR_CONTROL;

    // Locking write from the local side onto a held first semaphore
    sequence isa_lock_try_s;
        isa_req.wr && !vme_req.wr && isa_req.addr == ADDR_SEM_ONE
            && state_reg.sem_one[SEM_LOCK_BIT] && isa_req.wdata[SEM_LOCK_BIT];
    endsequence : isa_lock_try_s

    // Locking write from the backplane onto a held first semaphore
    sequence vme_lock_try_s;
        vme_req.wr && !isa_req.wr && vme_req.addr == ADDR_SEM_ONE
            && state_reg.sem_one[SEM_LOCK_BIT] && vme_req.wdata[SEM_LOCK_BIT];
    endsequence : vme_lock_try_s

    // Any local write onto a free second semaphore
    sequence isa_take_two_s;
        isa_req.wr && !vme_req.wr && isa_req.addr == ADDR_SEM_TWO && !state_reg.sem_two[SEM_LOCK_BIT];
    endsequence : isa_take_two_s

    // Acquire: locking write to a free semaphore, one quiet cycle, then a read back
    sequence isa_acquire_s;
        (isa_req.wr && !vme_req.wr && isa_req.addr == ADDR_SEM_ONE
            && !state_reg.sem_one[SEM_LOCK_BIT] && isa_req.wdata[SEM_LOCK_BIT])
        ##1 (!isa_req.wr && !vme_req.wr)
        ##1 (isa_req.rd && isa_req.addr == ADDR_SEM_ONE);
    endsequence : isa_acquire_s

    // A locked semaphore never takes a locking write, from either side
    sem_lock_a: assert property (@(posedge mclk) disable iff (!rstn)
        isa_lock_try_s |=> $stable(state_reg.sem_one)) else $error("locked semaphore overwritten");

    vme_lock_a: assert property (@(posedge mclk) disable iff (!rstn)
        vme_lock_try_s |=> $stable(state_reg.sem_one)) else $error("backplane broke a lock");

    // A free semaphore takes whatever is written
    sem_take_a: assert property (@(posedge mclk) disable iff (!rstn)
        isa_take_two_s |=> state_reg.sem_two == $past(isa_req.wdata)) else $error("free semaphore not taken");

    // The winner of an acquire reads back its own value
    acquire_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        isa_acquire_s |=> isa_rdata == $past(isa_req.wdata, 3)) else $error("acquire read back wrong");

    // Reset clears both semaphores
    sem_reset_a: assert property (@(posedge mclk) !rstn |=> state_reg.sem_one == 8'h00 && state_reg.sem_two == 8'h00)
        else $error("semaphores not cleared");

    // Backplane releases land in both semaphores
    vme_sem_a: assert property (@(posedge mclk) disable iff (!rstn)
        (vme_req.wr && vme_req.addr == ADDR_SEM_ONE && !vme_req.wdata[SEM_LOCK_BIT])
        |=> state_reg.sem_one == $past(vme_req.wdata)) else $error("backplane release lost");

    vme_two_a: assert property (@(posedge mclk) disable iff (!rstn)
        (vme_req.wr && vme_req.addr == ADDR_SEM_TWO && !vme_req.wdata[SEM_LOCK_BIT])
        |=> state_reg.sem_two == $past(vme_req.wdata)) else $error("backplane second release lost");

    // Slot register shows the live pins
    slot_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        (isa_req.rd && isa_req.addr == ADDR_SLOT)
        |=> isa_rdata == {2'h0, $past(pins.slot_parity_n), $past(pins.slot_n)}) else $error("slot read wrong");

    // Control register reads back what it holds
    ctrl_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        (isa_req.rd && isa_req.addr == ADDR_CONTROL) |=> isa_rdata == $past(state_reg.control))
        else $error("control read wrong");

    // Read data stands until the next read on its side
    isa_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        !isa_req.rd |=> $stable(isa_rdata)) else $error("local read data moved");

    vme_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        !vme_req.rd |=> $stable(vme_rdata)) else $error("backplane read data moved");

    // Addresses outside the map, DMA and acknowledge included, find nothing
    unmapped_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        (isa_req.rd && !isa_hit) |=> isa_rdata == UNMAPPED_READ) else $error("unmapped read wrong");

    // Abort switch and base type inputs
    abort_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        (vme_req.rd && vme_req.addr == ADDR_PORT_B) |=> vme_rdata[PORTB_ABORT_BIT] == $past(pins.abort_n))
        else $error("abort read wrong");

    type_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        (isa_req.rd && isa_req.addr == ADDR_PORT_C) |=> isa_rdata[3:2] == $past(pins.base_type))
        else $error("type read wrong");

    // Fault output follows port A bit 6 and reads back alone
    led_set_a: assert property (@(posedge mclk) disable iff (!rstn)
        (isa_req.wr && isa_req.addr == ADDR_PORT_A) |=> fault_led == $past(isa_req.wdata[PORTA_FAULT_BIT]))
        else $error("fault led wrong");

    porta_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        (isa_req.rd && isa_req.addr == ADDR_PORT_A) |=> isa_rdata == {1'h0, $past(fault_led), 6'h00})
        else $error("port a read wrong");

    // Neither control writes nor backplane port writes move the ports
    ctrl_keep_a: assert property (@(posedge mclk) disable iff (!rstn)
        (isa_req.wr && isa_req.addr == ADDR_CONTROL) |=> $stable(fault_led))
        else $error("control write moved port");

    vme_port_keep_a: assert property (@(posedge mclk) disable iff (!rstn)
        (vme_req.wr && !isa_req.wr && vme_req.addr != ADDR_SEM_ONE && vme_req.addr != ADDR_SEM_TWO)
        |=> $stable(fault_led) && $stable(state_reg.control)) else $error("backplane write moved port");

endmodule : issp_regs
`default_nettype wire

// [hw/issp_pkg.sv]
package issp_pkg;

    // Register addresses, low 16 bits of the I/O address
    localparam logic [15:0] ADDR_PORT_C = 16'h0844;
    localparam logic [15:0] ADDR_PORT_B = 16'h0845;
    localparam logic [15:0] ADDR_PORT_A = 16'h0846;
    localparam logic [15:0] ADDR_CONTROL = 16'h0847;
    localparam logic [15:0] ADDR_SEM_ONE = 16'h1004;
    localparam logic [15:0] ADDR_SEM_TWO = 16'h1005;
    localparam logic [15:0] ADDR_SLOT = 16'h1006;

    // Field positions
    localparam int SEM_LOCK_BIT = 7;
    localparam int PORTA_FAULT_BIT = 6;
    localparam int PORTB_ABORT_BIT = 7;
    localparam int PORTC_TYPE_LO = 2;
    localparam int SLOT_PARITY_BIT = 5;

    // Reset values and the value read from unmapped addresses
    localparam logic [7:0] SEM_RESET = 8'h00;
    localparam logic [7:0] PORT_A_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'hff;

    // One register access from a bus side
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } issp_req_t;

    // Backplane and front panel inputs
    typedef struct packed {
        logic [4:0] slot_n;
        logic slot_parity_n;
        logic abort_n;
        logic [1:0] base_type;
    } issp_pins_t;

    // All state of the block
    typedef struct packed {
        logic [7:0] sem_one;
        logic [7:0] sem_two;
        logic [7:0] port_a;
        logic [7:0] control;
        logic [7:0] isa_rdata;
        logic [7:0] vme_rdata;
    } issp_state_t;

endpackage : issp_pkg

// [verif/issp_master.sv]
`timescale 1ns/1ns
`default_nettype none
module issp_master (
    input wire logic mclk,
    output issp_pkg::issp_req_t req,
    input wire logic [7:0] rdata
);
    import issp_pkg::*;
    // Idle bus at time zero
    initial req = '0;
    // One write, released lines show inverted values
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        req <= '{1'b0, 1'b1, a, v};
        @(posedge mclk);
        req <= '{1'b0, 1'b0, ~a, ~v};
        @(posedge mclk);
    endtask : wr
    // One read, data taken once settled
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        req <= '{1'b1, 1'b0, a, ~req.wdata};
        @(posedge mclk);
        req <= '{1'b0, 1'b0, ~a, ~req.wdata};
        @(posedge mclk);
        @(negedge mclk);
        v = rdata;
        @(posedge mclk);
    endtask : rd
endmodule : issp_master
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import issp_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    issp_req_t isa_req, vme_req;
    logic [7:0] isa_rdata, vme_rdata, d;
    logic [15:0] a;
    issp_pins_t pins = '0;
    logic fault_led;
    int errors = 0;
    int n_checks = 0;
    // Clock, design and both masters
    always #4 mclk = ~mclk;
    issp_regs dut_u (.mclk(mclk), .rstn(rstn), .isa_req(isa_req), .isa_rdata(isa_rdata),
        .vme_req(vme_req), .vme_rdata(vme_rdata), .pins(pins), .fault_led(fault_led));
    issp_master isa_m (.mclk(mclk), .req(isa_req), .rdata(isa_rdata));
    issp_master vme_m (.mclk(mclk), .req(vme_req), .rdata(vme_rdata));
    // Compare and count
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // Local read and compare
    task automatic rc(input logic [15:0] ad, input logic [7:0] e);
        isa_m.rd(ad, d);
        chk($sformatf("reg %h", ad), e, d);
    endtask : rc
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict
    // Hang guard
    initial begin
        #100000;
        errors++;
        print_verdict();
    end
    // Test sequence
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rc(ADDR_SEM_ONE, SEM_RESET);
        rc(ADDR_SEM_TWO, SEM_RESET);
        rc(ADDR_PORT_A, PORT_A_RESET);
        $display("test reset done");
        for (int s = 0; s < 2; s++) begin
            a = s ? ADDR_SEM_TWO : ADDR_SEM_ONE;
            isa_m.wr(a, 8'h80);
            isa_m.wr(a, 8'h85);
            rc(a, 8'h80);
            rc(s ? ADDR_SEM_ONE : ADDR_SEM_TWO, s ? 8'h81 : 8'h00);
            vme_m.wr(a, 8'h00);
            vme_m.wr(a, 8'h81);
            vme_m.rd(a, d);
            chk("vme sem", 8'h81, d);
        end
        $display("test semaphore done");
        vme_m.wr(ADDR_SEM_ONE, 8'h00);
        isa_m.wr(ADDR_SEM_ONE, 8'h83);
        rc(ADDR_SEM_ONE, 8'h83);
        vme_m.wr(ADDR_SEM_ONE, 8'h84);
        vme_m.rd(ADDR_SEM_ONE, d);
        chk("vme sem lost", 8'h83, d);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rc(ADDR_SEM_ONE, SEM_RESET);
        rc(ADDR_SEM_TWO, SEM_RESET);
        $display("test acquire done");
        pins <= '{5'h15, 1'b0, 1'b0, 2'b00};
        rc(ADDR_SLOT, 8'h15);
        rc(ADDR_PORT_B, 8'h00);
        pins <= '{5'h0a, 1'b1, 1'b1, 2'b00};
        rc(ADDR_SLOT, 8'h2a);
        rc(ADDR_PORT_B, 8'h80);
        for (int t = 0; t < 4; t++) begin
            pins.base_type <= t[1:0];
            rc(ADDR_PORT_C, {4'h0, t[1:0], 2'b00});
        end
        $display("test pins done");
        isa_m.wr(ADDR_PORT_A, 8'hff);
        isa_m.wr(ADDR_CONTROL, 8'h5a);
        isa_m.wr(ADDR_PORT_C, 8'h00);
        vme_m.wr(ADDR_PORT_A, 8'h00);
        rc(ADDR_PORT_A, 8'h40);
        chk("fault_led", 8'h01, {7'h0, fault_led});
        rc(ADDR_CONTROL, 8'h5a);
        rc(ADDR_PORT_C, 8'h0c);
        rc(ADDR_PORT_B, 8'h80);
        rc(16'h0000, UNMAPPED_READ);
        rc(16'h1007, UNMAPPED_READ);
        rc(16'h0848, UNMAPPED_READ);
        $display("test ports done");
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
